// ==== common/fpen_defs.svh ====
// constants for the single-precision encode and normalize datapath
`ifndef FPEN_DEFS_SVH
`define FPEN_DEFS_SVH
`define FPEN_SIGN_BIT 31
`define FPEN_EXP_HI 30
`define FPEN_EXP_LO 23
`define FPEN_FRAC_HI 22
`define FPEN_FRAC_LO 0
`define FPEN_EXP_W 8
`define FPEN_FRAC_W 23
`define FPEN_SIG_W 24
`define FPEN_BIAS 10'sh07f
`define FPEN_EXP_MAX 8'hff
`define FPEN_EXP_NORM_MAX 8'hfe
`define FPEN_TRUE_EXP_MIN 10'sh382
`define FPEN_TRUE_EXP_MAX 10'sh07f
`define FPEN_LAT_CYCLES 1
`endif

// ==== common/fpen_pkg.sv ====
// types for the single-precision encode and normalize datapath
package fpen_pkg;
  typedef enum logic [5:0] {
    FPEN_CLS_ZERO = 6'h01,
    FPEN_CLS_DENORM = 6'h02,
    FPEN_CLS_NORMAL = 6'h04,
    FPEN_CLS_INF = 6'h08,
    FPEN_CLS_NAN = 6'h10,
    FPEN_CLS_INDEF = 6'h20
  } fpen_class_t;
  typedef enum logic [1:0] {
    FPEN_ST_IDLE = 2'h1,
    FPEN_ST_DENORM = 2'h2
  } fpen_state_t;
endpackage

// ==== verilog/fpen_classify.sv ====
// operand field split and class decode for one single-precision word
`include "fpen_defs.svh"
module fpen_classify (
  input wire logic [31:0] word,
  output logic sign,
  output logic [7:0] exp_biased,
  output logic [23:0] significand,
  output fpen_pkg::fpen_class_t cls,
  output logic quiet
);
  import fpen_pkg::*;
  wire [22:0] frac = word[`FPEN_FRAC_HI:`FPEN_FRAC_LO];
  wire exp_zero = exp_biased == 8'h00;
  wire exp_max = exp_biased == `FPEN_EXP_MAX;
  wire frac_zero = frac == 23'h000000;
  // indefinite: negative quiet nan with only the top fraction bit set
  wire is_indef = exp_max && word[`FPEN_SIGN_BIT] && frac == 23'h400000;
  assign sign = word[`FPEN_SIGN_BIT];
  assign exp_biased = word[`FPEN_EXP_HI:`FPEN_EXP_LO];
  assign significand = {~exp_zero, frac}; // hidden integer bit
  assign quiet = exp_max && !frac_zero && frac[22];
  always_comb
  begin
    if (exp_zero && frac_zero)
      cls = FPEN_CLS_ZERO;
    else if (exp_zero)
      cls = FPEN_CLS_DENORM;
    else if (exp_max && frac_zero)
      cls = FPEN_CLS_INF;
    else if (is_indef)
      cls = FPEN_CLS_INDEF;
    else if (exp_max)
      cls = FPEN_CLS_NAN;
    else
      cls = FPEN_CLS_NORMAL;
  end
endmodule // fpen_classify

// ==== verilog/fpen_encode_normalize.sv ====
// single-precision operand classifier and result normalizer / denormalizer
// Contract
// - sign bit 0 means positive, 1 means negative.
// - significand is integer bit plus fraction; integer bit is implied.
// - stored exponent equals true exponent plus 127.
// - nonzero normalized values have integer bit one, magnitude in [1,2).
// - normalizing removes leading zeros, decrementing exponent per bit.
// - biased exponent 1..254 is normalized finite, true -126..+127.
// - biased exponent zero is denormal with integer bit zero.
// - below -126, shift right one place per step until exponent is -126.
// - if all significant bits shift out, deliver zero.
// - zero carries either sign; both zeros compare equal.
// - every encoding falls in exactly one class.
// - normalize when range allows; denormal only when impossible.
// - creating a denormal result raises underflow.
// - a denormal source operand raises denormal-operand.
// - infinity is exponent 255 with zero fraction, signed.
// - NaN is exponent 255 with nonzero fraction; fraction msb marks quiet.
`include "fpen_defs.svh"
module fpen_encode_normalize #(
  parameter int SIG_W = `FPEN_SIG_W
) (
  input wire logic CLK,
  input wire logic RST_N,
  // operand side
  input wire logic OPA_VALID,
  input wire logic [31:0] OPA_WORD,
  input wire logic [31:0] OPB_WORD,
  output logic OPA_SIGN,
  output logic [7:0] OPA_EXP,
  output logic [23:0] OPA_SIG,
  output fpen_pkg::fpen_class_t OPA_CLASS,
  output logic OPA_QUIET,
  output fpen_pkg::fpen_class_t OPB_CLASS,
  output logic OPS_EQUAL,
  output logic DENORM_OPERAND,
  // result side
  input wire logic RES_VALID,
  output logic RES_READY,
  input wire logic RES_SIGN,
  input wire logic signed [9:0] RES_EXP,
  input wire logic [SIG_W-1:0] RES_SIG,
  output logic OUT_VALID,
  output logic [31:0] OUT_WORD,
  output logic UNDERFLOW
);
  import fpen_pkg::*;

  logic rst_s1;
  logic rst_n_q;
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_s1 <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n_q <= rst_s1;
    end
  end

  // operand classification, one decoder per operand
  localparam int NUM_OPS = 2;
  wire [NUM_OPS-1:0][31:0] op_word = {OPB_WORD, OPA_WORD};
  wire [NUM_OPS-1:0] op_sign;
  wire [NUM_OPS-1:0][7:0] op_exp;
  wire [NUM_OPS-1:0][23:0] op_sig;
  wire [NUM_OPS-1:0][5:0] op_cls;
  wire [NUM_OPS-1:0] op_quiet;
  for (genvar g = 0; g < NUM_OPS; g++)
  begin : g_op
    fpen_classify u_cls (
      .word(op_word[g]),
      .sign(op_sign[g]),
      .exp_biased(op_exp[g]),
      .significand(op_sig[g]),
      .cls(op_cls[g]),
      .quiet(op_quiet[g])
    );
  end
  assign OPA_SIGN = op_sign[0];
  assign OPA_EXP = op_exp[0];
  assign OPA_SIG = op_sig[0];
  assign OPA_CLASS = fpen_class_t'(op_cls[0]);
  assign OPA_QUIET = op_quiet[0];
  assign OPB_CLASS = fpen_class_t'(op_cls[1]);
  wire both_zero = OPA_CLASS == FPEN_CLS_ZERO && OPB_CLASS == FPEN_CLS_ZERO;
  wire any_nan = OPA_CLASS inside {FPEN_CLS_NAN, FPEN_CLS_INDEF} ||
                 OPB_CLASS inside {FPEN_CLS_NAN, FPEN_CLS_INDEF};
  assign OPS_EQUAL = both_zero || (!any_nan && OPA_WORD == OPB_WORD);
  wire denorm_in = OPA_VALID &&
                   (OPA_CLASS == FPEN_CLS_DENORM || OPB_CLASS == FPEN_CLS_DENORM);

  // leading zero count of the incoming significand
  localparam int LZ_W = $clog2(SIG_W + 1);
  logic [LZ_W-1:0] lz;
  always_comb
  begin
    lz = LZ_W'(SIG_W);
    for (int i = 0; i < SIG_W; i++)
      if (RES_SIG[i])
        lz = LZ_W'(SIG_W - 1 - i);
  end
  wire sig_zero = RES_SIG == '0;
  wire signed [10:0] norm_exp = 11'(RES_EXP) - 11'(lz);
  wire [SIG_W-1:0] norm_sig = RES_SIG << lz;
  wire signed [10:0] exp_min = 11'(`FPEN_TRUE_EXP_MIN);
  wire tiny = norm_exp < exp_min;
  wire [7:0] norm_biased = 8'(norm_exp + 11'(`FPEN_BIAS));

  // gradual underflow sequencer
  fpen_state_t state;
  fpen_state_t next_state;
  logic signed [10:0] dn_exp;
  logic [SIG_W-1:0] dn_sig;
  logic dn_sign;
  assign RES_READY = state == FPEN_ST_IDLE;
  wire take = RES_VALID && RES_READY;
  wire dn_done = dn_exp >= exp_min || dn_sig == '0;
  always_comb
  begin
    case (state)
      FPEN_ST_IDLE: next_state = (take && !sig_zero && tiny) ? FPEN_ST_DENORM : FPEN_ST_IDLE;
      FPEN_ST_DENORM: next_state = dn_done ? FPEN_ST_IDLE : FPEN_ST_DENORM;
      default: next_state = FPEN_ST_IDLE;
    endcase
  end
  wire [22:0] dn_frac = dn_sig[SIG_W-2 -: 23];
  wire [31:0] dn_word = {dn_sign, 8'h00, dn_frac};
  wire [31:0] nrm_word = sig_zero ? {RES_SIGN, 31'h0} :
                         {RES_SIGN, norm_biased, norm_sig[SIG_W-2 -: 23]};
  wire dn_fin = state == FPEN_ST_DENORM && dn_done;
  // named selects keep the register processes down to plain loads
  wire take_nrm = take && (sig_zero || !tiny);
  wire dn_step = state == FPEN_ST_DENORM && !dn_done;
  wire ufl_evt = dn_fin && dn_sig != '0;
  wire next_out_valid = take_nrm || dn_fin;
  wire [31:0] next_out_word = take_nrm ? nrm_word : dn_word;

  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      state <= FPEN_ST_IDLE;
    else
      state <= next_state;
  end

  // working copy that the denormalizing steps shift
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      dn_exp <= 11'sh000;
      dn_sig <= '0;
      dn_sign <= 1'b0;
    end
    else if (take)
    begin
      dn_exp <= norm_exp;
      dn_sig <= norm_sig;
      dn_sign <= RES_SIGN;
    end
    else if (dn_step)
    begin
      dn_exp <= dn_exp + 11'sh001;
      dn_sig <= dn_sig >> 1;
    end
  end

  // encoded result holds until the next one
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      OUT_VALID <= 1'b0;
      OUT_WORD <= 32'h0;
    end
    else
    begin
      OUT_VALID <= next_out_valid;
      if (next_out_valid)
        OUT_WORD <= next_out_word;
    end
  end

  // underflow pulses for one cycle; denormal operand follows denorm_in one cycle later
  always_ff @(posedge CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      UNDERFLOW <= 1'b0;
      DENORM_OPERAND <= 1'b0;
    end
    else
    begin
      UNDERFLOW <= ufl_evt;
      DENORM_OPERAND <= denorm_in;
    end
  end

  AST_NORM_LEAD: assert property (@(posedge CLK) disable iff (!rst_n_q)
    take && !sig_zero && !tiny |=> OUT_VALID && OUT_WORD[30:23] != 8'h00)
    else $error("normalized result lost its exponent");
  AST_EXP_RANGE: assert property (@(posedge CLK) disable iff (!rst_n_q)
    OUT_VALID |-> OUT_WORD[30:23] != 8'hff)
    else $error("result exponent left the finite range");
  AST_DN_EXP: assert property (@(posedge CLK) disable iff (!rst_n_q)
    state == FPEN_ST_DENORM && !dn_done |=> dn_exp == $past(dn_exp) + 11'sh001)
    else $error("denormal step did not advance exponent");
  AST_DN_END: assert property (@(posedge CLK) disable iff (!rst_n_q)
    take && !sig_zero && tiny |-> ##[1:30] OUT_VALID)
    else $error("denormalization did not finish");
  AST_FLUSH: assert property (@(posedge CLK) disable iff (!rst_n_q)
    dn_fin && dn_sig == '0 |=> OUT_WORD[30:0] == 31'h0 && !UNDERFLOW)
    else $error("fully shifted result not zero");
  AST_UFL: assert property (@(posedge CLK) disable iff (!rst_n_q)
    UNDERFLOW |-> OUT_VALID && OUT_WORD[30:23] == 8'h00 && OUT_WORD[22:0] != 23'h0)
    else $error("underflow without denormal result");
  AST_DOP: assert property (@(posedge CLK) disable iff (!rst_n_q)
    OPA_VALID && OPA_CLASS == FPEN_CLS_DENORM |=> DENORM_OPERAND)
    else $error("denormal operand not flagged");
  AST_PULSE: assert property (@(posedge CLK) disable iff (!rst_n_q)
    UNDERFLOW |=> !UNDERFLOW)
    else $error("underflow longer than one cycle");
  AST_ZERO_EQ: assert property (@(posedge CLK) disable iff (!rst_n_q)
    OPA_WORD[30:0] == 31'h0 && OPB_WORD[30:0] == 31'h0 |-> OPS_EQUAL)
    else $error("signed zeros compared unequal");
  AST_ONEHOT: assert property (@(posedge CLK) disable iff (!rst_n_q)
    $onehot(OPA_CLASS))
    else $error("operand class not unique");

  // operand side checks
  AST_HIDDEN: assert property (@(posedge CLK) disable iff (!rst_n_q)
    OPA_SIG[23] == (OPA_EXP != 8'h00) && op_sig[1][23] == (op_exp[1] != 8'h00))
    else $error("implied integer bit wrong");
  AST_B_FIELDS: assert property (@(posedge CLK) disable iff (!rst_n_q)
    {op_sign[1], op_exp[1], op_sig[1][22:0]} == OPB_WORD)
    else $error("second operand fields misplaced");
  AST_QUIET_A: assert property (@(posedge CLK) disable iff (!rst_n_q)
    OPA_QUIET |-> OPA_CLASS inside {FPEN_CLS_NAN, FPEN_CLS_INDEF})
    else $error("quiet flag on a number");
  AST_QUIET_B: assert property (@(posedge CLK) disable iff (!rst_n_q)
    op_quiet[1] |-> OPB_CLASS inside {FPEN_CLS_NAN, FPEN_CLS_INDEF})
    else $error("quiet flag on a number");
  AST_NORM_RANGE: assert property (@(posedge CLK) disable iff (!rst_n_q)
    OPA_CLASS == FPEN_CLS_NORMAL |-> OPA_EXP != 8'h00 && OPA_EXP != 8'hff)
    else $error("normal class outside the finite exponent range");
  AST_DENORM_CLS: assert property (@(posedge CLK) disable iff (!rst_n_q)
    OPA_EXP == 8'h00 && OPA_SIG[22:0] != 23'h0 |-> OPA_CLASS == FPEN_CLS_DENORM)
    else $error("denormal operand misclassified");
  AST_INF_CLS: assert property (@(posedge CLK) disable iff (!rst_n_q)
    OPA_EXP == 8'hff && OPA_SIG[22:0] == 23'h0 |-> OPA_CLASS == FPEN_CLS_INF)
    else $error("infinity misclassified");
  AST_NAN_CLS: assert property (@(posedge CLK) disable iff (!rst_n_q)
    OPA_EXP == 8'hff && OPA_SIG[22:0] != 23'h0 |-> OPA_CLASS inside {FPEN_CLS_NAN, FPEN_CLS_INDEF})
    else $error("nan misclassified");
  AST_ONEHOT_B: assert property (@(posedge CLK) disable iff (!rst_n_q)
    $onehot(OPB_CLASS))
    else $error("second operand class not unique");
  AST_DOP_B: assert property (@(posedge CLK) disable iff (!rst_n_q)
    OPA_VALID && OPB_CLASS == FPEN_CLS_DENORM |=> DENORM_OPERAND)
    else $error("denormal second operand not flagged");
  AST_DOP_NONE: assert property (@(posedge CLK) disable iff (!rst_n_q)
    OPA_VALID && OPA_CLASS != FPEN_CLS_DENORM && OPB_CLASS != FPEN_CLS_DENORM |=> !DENORM_OPERAND)
    else $error("denormal operand flagged without a denormal");
  AST_DOP_IDLE: assert property (@(posedge CLK) disable iff (!rst_n_q)
    !OPA_VALID |=> !DENORM_OPERAND)
    else $error("denormal operand flagged with no computation");

  // result side checks
  AST_READY_LOW: assert property (@(posedge CLK) disable iff (!rst_n_q)
    state == FPEN_ST_DENORM |-> !RES_READY)
    else $error("result accepted while denormalizing");
  AST_DN_MIN: assert property (@(posedge CLK) disable iff (!rst_n_q)
    dn_fin && dn_sig != '0 |-> dn_exp == exp_min)
    else $error("denormal delivered away from the minimum exponent");
  AST_DN_SHIFT: assert property (@(posedge CLK) disable iff (!rst_n_q)
    dn_step |=> dn_sig == $past(dn_sig) >> 1)
    else $error("denormal step did not shift by one");
  AST_NRM_SIGN: assert property (@(posedge CLK) disable iff (!rst_n_q)
    take_nrm |=> OUT_WORD[31] == $past(RES_SIGN))
    else $error("normalized result lost its sign");
  AST_DN_SIGN: assert property (@(posedge CLK) disable iff (!rst_n_q)
    dn_fin |=> OUT_WORD[31] == $past(dn_sign))
    else $error("denormal result lost its sign");
  AST_ZERO_RES: assert property (@(posedge CLK) disable iff (!rst_n_q)
    take && sig_zero |=> OUT_VALID && OUT_WORD[30:0] == 31'h0 && !UNDERFLOW)
    else $error("zero significand not delivered as signed zero");
  AST_NO_DN_NRM: assert property (@(posedge CLK) disable iff (!rst_n_q)
    take && !sig_zero && !tiny |=> state == FPEN_ST_IDLE)
    else $error("denormalized a result that could be normalized");
  AST_STATE_OH: assert property (@(posedge CLK) disable iff (!rst_n_q)
    $onehot(state))
    else $error("sequencer state not one-hot");
  AST_OUT_HOLD: assert property (@(posedge CLK) disable iff (!rst_n_q)
    !take_nrm && !dn_fin |=> $stable(OUT_WORD))
    else $error("result word changed with no result");
  AST_UFL_SRC: assert property (@(posedge CLK) disable iff (!rst_n_q)
    UNDERFLOW |-> $past(state) == FPEN_ST_DENORM)
    else $error("underflow without a denormalizing pass");
endmodule // fpen_encode_normalize

// ==== sim/fpen_pipe_model.sv ====
// far-side model of the execution pipeline that hands results to the encoder
module fpen_pipe_model (
  input wire logic clk,
  input wire logic res_ready,
  output logic res_valid,
  output logic res_sign,
  output logic signed [9:0] res_exp,
  output logic [23:0] res_sig
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    res_valid = 1'b0;
    res_sign = 1'b0;
    res_exp = 10'sh000;
    res_sig = 24'h000000;
  end
  // called at a falling edge; returns at the rising edge that takes the request
  task automatic send(input logic s, input logic signed [9:0] e, input logic [23:0] g);
    res_valid = 1'b1;
    res_sign = s;
    res_exp = e;
    res_sig = g;
    while (res_ready !== 1'b1)
      @(negedge clk);
    @(posedge clk);
  endtask
  // released fields show the inverse, never the last value
  task automatic idle();
    res_valid = 1'b0;
    res_sign = ~res_sign;
    res_exp = ~res_exp;
    res_sig = ~res_sig;
  endtask
endmodule // fpen_pipe_model

// ==== sim/fp_single_encode_normalize_tb.sv ====
// self-checking bench for the single-precision encode and normalize datapath
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) \
    begin \
      error_cnt++; \
      $display("unexpected %s expected %h seen %h", nm, ex, got); \
    end \
  end
module fp_single_encode_normalize_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fpen_pkg::*;
  int error_cnt = 0;
  int check_count = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic opa_valid = 1'b0;
  logic [31:0] opa_word = 32'h0;
  logic [31:0] opb_word = 32'h0;
  logic res_valid, res_sign, res_ready, opa_sign, opa_quiet, ops_equal, denorm_op;
  logic out_valid, underflow;
  logic signed [9:0] res_exp;
  logic [23:0] res_sig, opa_sig;
  logic [7:0] opa_exp;
  logic [31:0] out_word;
  fpen_class_t opa_class, opb_class;
  always #20 clk = ~clk;
  fpen_pipe_model pipe (.clk(clk), .res_ready(res_ready), .res_valid(res_valid),
    .res_sign(res_sign), .res_exp(res_exp), .res_sig(res_sig));
  fpen_encode_normalize dut (.CLK(clk), .RST_N(rst_n), .OPA_VALID(opa_valid),
    .OPA_WORD(opa_word), .OPB_WORD(opb_word), .OPA_SIGN(opa_sign), .OPA_EXP(opa_exp),
    .OPA_SIG(opa_sig), .OPA_CLASS(opa_class), .OPA_QUIET(opa_quiet), .OPB_CLASS(opb_class),
    .OPS_EQUAL(ops_equal), .DENORM_OPERAND(denorm_op), .RES_VALID(res_valid),
    .RES_READY(res_ready), .RES_SIGN(res_sign), .RES_EXP(res_exp), .RES_SIG(res_sig),
    .OUT_VALID(out_valid), .OUT_WORD(out_word), .UNDERFLOW(underflow));
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic ops(input logic [31:0] a, input logic [31:0] b);
    @(negedge clk);
    opa_word = a;
    opb_word = b;
    #1;
  endtask
  task automatic cls(input logic [31:0] w, input fpen_class_t c, input logic q);
    ops(w, w);
    `CHK("class a", c, opa_class)
    `CHK("class b", c, opb_class)
    `CHK("quiet", q, opa_quiet)
  endtask
  task automatic run_res(input logic s, input logic signed [9:0] e, input logic [23:0] g,
    input logic [31:0] w, input logic uf, input int lat);
    int n;
    n = 0;
    pipe.send(s, e, g);
    @(negedge clk);
    pipe.idle();
    if (lat > 0)
      `CHK("ready", 1'b0, res_ready)
    while (out_valid !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("done", 1'b1, out_valid)
    `CHK("word", w, out_word)
    `CHK("underflow", uf, underflow)
    if (lat >= 0)
      `CHK("latency", lat, n)
    @(negedge clk);
    `CHK("pulse", 1'b0, out_valid)
  endtask
  task automatic t_b2b();
    @(negedge clk);
    pipe.send(1'b0, 10'sd7, 24'hb22000);
    @(negedge clk);
    `CHK("b2b word", 32'h43322000, out_word)
    pipe.send(1'b1, 10'sd0, 24'h800000);
    @(negedge clk);
    pipe.idle();
    `CHK("b2b word", 32'hbf800000, out_word)
    `CHK("b2b valid", 1'b1, out_valid)
  endtask
  task automatic t_dop();
    @(negedge clk);
    opa_word = 32'h00400000;
    opb_word = 32'h3f800000;
    opa_valid = 1'b1;
    @(negedge clk);
    opa_valid = 1'b0;
    `CHK("denorm op", 1'b1, denorm_op)
    @(negedge clk);
    `CHK("denorm op", 1'b0, denorm_op)
    opa_word = 32'h3f800000;
    opb_word = 32'h00000001;
    opa_valid = 1'b1;
    @(negedge clk);
    `CHK("denorm op", 1'b1, denorm_op)
    opb_word = 32'h3f800000;
    @(negedge clk);
    opa_valid = 1'b0;
    `CHK("denorm op", 1'b0, denorm_op)
  endtask
  initial
  begin
    #80000;
    error_cnt++;
    end_sim();
  end
  initial
  begin
    repeat (20) @(negedge clk);
    `CHK("reset out", 2'b00, {out_valid, underflow})
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    ops(32'h43322000, 32'h0);
    `CHK("fields", {1'b0, 8'h86, 24'hb22000}, {opa_sign, opa_exp, opa_sig})
    ops(32'h80000001, 32'h0);
    `CHK("fields", {1'b1, 8'h00, 24'h000001}, {opa_sign, opa_exp, opa_sig})
    `CHK("equal", 1'b0, ops_equal)
    ops(32'h00000000, 32'h80000000);
    `CHK("equal", 1'b1, ops_equal)
    ops(32'h7fc00000, 32'h7fc00000);
    `CHK("equal", 1'b0, ops_equal)
    cls(32'h80000000, FPEN_CLS_ZERO, 1'b0);
    cls(32'h007fffff, FPEN_CLS_DENORM, 1'b0);
    cls(32'h00800000, FPEN_CLS_NORMAL, 1'b0);
    cls(32'h7f7fffff, FPEN_CLS_NORMAL, 1'b0);
    cls(32'hff800000, FPEN_CLS_INF, 1'b0);
    cls(32'h7fc00001, FPEN_CLS_NAN, 1'b1);
    cls(32'hff800001, FPEN_CLS_NAN, 1'b0);
    cls(32'hffc00000, FPEN_CLS_INDEF, 1'b1);
    t_dop();
    run_res(1'b0, 10'sd7, 24'hb22000, 32'h43322000, 1'b0, 0);
    run_res(1'b0, 10'sd7, 24'h0b2200, 32'h41322000, 1'b0, 0);
    run_res(1'b0, -10'sd126, 24'h800000, 32'h00800000, 1'b0, 0);
    run_res(1'b0, 10'sd127, 24'hffffff, 32'h7f7fffff, 1'b0, 0);
    run_res(1'b0, -10'sd129, 24'hae0000, 32'h0015c000, 1'b1, 4);
    run_res(1'b1, -10'sd129, 24'hae0000, 32'h8015c000, 1'b1, 4);
    run_res(1'b0, -10'sd127, 24'h400000, 32'h00200000, 1'b1, 3);
    run_res(1'b0, -10'sd151, 24'h800000, 32'h00000000, 1'b0, 25);
    run_res(1'b1, 10'sd5, 24'h000000, 32'h80000000, 1'b0, 0);
    t_b2b();
    end_sim();
  end
endmodule // fp_single_encode_normalize_tb
